// file: hdl/su_defines.vh
// Constants shared by the serial unit and its transmit FIFO
`ifndef SU_DEFINES_VH
`define SU_DEFINES_VH

// Serial mode select codes
`define SU_MODE_OFF      3'h0
`define SU_MODE_SYNC     3'h1
`define SU_MODE_I2C      3'h2
`define SU_MODE_SIM      3'h5

// Data word and FIFO shape
`define SU_WORD_W        8
`define SU_FIFO_DEPTH    32

// I2C divider floor: SCL level needs up to three count cycles to settle
`define SU_I2C_MIN_DIV   8'h03

// Reset values
`define SU_RST_WORD      8'h00
`define SU_RST_DIV       10'h000
`define SU_RST_BITCNT    3'h0

// Condition generator states
`define SU_G_IDLE        2'h0
`define SU_G_START       2'h1
`define SU_G_STOP        2'h2
`define SU_G_RESTART     2'h3

`endif

// file: hdl/su_fifo.v
// Parameterised flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module su_fifo #(
  parameter WIDTH = 8,                        // Word width
  parameter DEPTH = 32,                       // Number of words
  parameter AW    = 5                         // Index width, log2 of DEPTH
) (
  input  wire             clk_in,             // System clock
  input  wire             rst_n_in,           // Synchronous reset, active low
  input  wire [WIDTH-1:0] in_data_in,         // Write word
  input  wire             in_valid_in,        // Write word valid
  output reg              in_ready_out,       // Room for a word
  output wire [WIDTH-1:0] out_data_out,       // Oldest word
  output reg              out_valid_out,      // Oldest word valid
  input  wire             out_ready_in        // Drain side accepts
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];            // Storage
  reg [AW-1:0]    wr_idx;                     // Write index
  reg [AW-1:0]    rd_idx;                     // Read index
  reg [AW:0]      count;                      // Words held
  wire            push = in_valid_in & in_ready_out;   // Accepted write
  wire            pop  = out_valid_out & out_ready_in; // Accepted read
  wire [AW:0]     next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  assign out_data_out = mem[rd_idx];

  ////////////////////////////////////////////////////////////////////////////
  // Pointers and registered flags; flags come from the next count so
  // that full and empty are honest on the very next cycle
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      wr_idx        <= {AW{1'b0}};
      rd_idx        <= {AW{1'b0}};
      count         <= {(AW+1){1'b0}};
      in_ready_out  <= 1'b1;
      out_valid_out <= 1'b0;
    end else begin
      if (push) begin
        wr_idx <= wr_idx + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_idx <= rd_idx + {{(AW-1){1'b0}}, 1'b1};
      end
      count         <= next_count;
      in_ready_out  <= (next_count != DEPTH[AW:0]);
      out_valid_out <= (next_count != {(AW+1){1'b0}});
    end
  end

  // Storage has no reset; contents are only read behind out_valid
  always @(posedge clk_in) begin
    if (push) begin
      mem[wr_idx] <= in_data_in;
    end
  end
endmodule // su_fifo
`default_nettype wire

// file: hdl/su_serial_unit.v
// Multi-mode serial unit: clock synchronous shifter, I2C conditions, SIM irq
`timescale 1ns/1ps
`default_nettype none
`include "su_defines.vh"
module su_serial_unit #(
  parameter WORD_W     = `SU_WORD_W,          // Data word width
  parameter FIFO_DEPTH = `SU_FIFO_DEPTH       // Transmit FIFO depth
) (
  input  wire              clk_in,                  // 200 MHz system clock
  input  wire              rst_n_in,                // Synchronous reset, active low
  input  wire [2:0]        serial_mode_select_in,   // Mode code, zero is off
  input  wire              clk_open_drain_sel_in,   // Clock pin open drain
  input  wire              internal_clk_sel_in,     // One: internal shift clock
  input  wire              clock_polarity_sel_in,   // Edge swap
  input  wire              tx_enable_bit_in,        // Transmission enabled
  input  wire              rx_enable_bit_in,        // Reception enabled
  input  wire              rts_enable_in,           // RTS handshake on
  input  wire              cts_enable_in,           // CTS handshake on
  input  wire              cts_n_in,                // CTS pin, active low
  input  wire [7:0]        baud_div_in,             // Internal clock divider
  input  wire [7:0]        i2c_baud_divider_in,     // I2C half-period divider
  input  wire [2:0]        sda_delay_in,            // SDA delay in count cycles
  input  wire              condition_output_select_in, // Conditions drive pins
  input  wire              start_request_in,        // Start request bit
  input  wire              restart_request_in,      // Restart request bit
  input  wire              stop_request_in,         // Stop request bit
  input  wire              tx_irq_source_sel_in,    // One: transmission completed
  input  wire              error_output_enable_in,  // SIM error output enable
  input  wire              irq_clear_in,            // Clears both request flags
  input  wire [WORD_W-1:0] tx_data_in,              // Word for tx_buffer path
  input  wire              tx_valid_in,             // Word valid
  output wire              tx_ready_out,            // FIFO has room
  input  wire              rx_read_in,              // Pulse: rx_buffer read
  output reg  [WORD_W-1:0] rx_buffer_out,           // Received word
  output reg               rx_buffer_full_flag_out, // rx_buffer holds a word
  output reg               overrun_flag_out,        // Overrun occurred
  output reg               rx_irq_out,              // Receive request flag
  output reg               tx_irq_out,              // Transmit request flag
  output reg               tx_shift_empty_out,      // Shift register empty
  output reg               tx_buffer_empty_flag_out,// tx_buffer empty
  output reg               cond_busy_out,           // Condition in progress
  input  wire              serial_clock_pin_in,     // Clock pin level
  output reg               serial_clock_pin_out,    // Clock pin drive level
  output reg               serial_clock_pin_oe_n_out, // Clock pin enable, low drives
  input  wire              receive_data_pin_in,     // Receive data pin
  output reg               transmit_data_pin_out,   // Transmit data / SDA level
  output reg               transmit_data_pin_oe_n_out, // Data pin enable, low drives
  output reg               rts_n_out                // RTS pin, active low
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  reg              clk_s1, clk_s2, clk_s3;    // Clock pin synchroniser and history
  reg              cts_s1, cts_s2;            // CTS synchroniser
  reg              rxd_s1, rxd_s2;            // Receive data synchroniser
  reg [WORD_W-1:0] tx_buf;                    // tx_buffer contents
  reg              tx_full;                   // tx_buffer holds a word
  reg [WORD_W-1:0] tx_sh;                     // Transmit shift register
  reg [WORD_W-1:0] rx_sh;                     // Receive shift register
  reg [2:0]        bitcnt;                    // Bits sampled in this word
  reg              busy;                      // Word in flight
  reg              rx_on;                     // Word also received
  reg              sclk_int;                  // Internal shift clock level
  reg [7:0]        div_cnt;                   // Internal clock divider count
  reg              txd;                       // Shifted data level
  reg [1:0]        g_state;                   // Condition generator state
  reg [9:0]        g_cnt;                     // Condition timer
  reg              scl_gen, sda_gen;          // Condition pin levels
  reg [2:0]        req_prev;                  // Request bits last cycle
  reg [2:0]        req_pend;                  // Start, restart, stop pending
  reg              tx_cond_prev;              // Transmit source last cycle
  wire [WORD_W-1:0] fifo_data;                // FIFO head
  wire             fifo_valid;                // FIFO head valid

  wire mode_on   = (serial_mode_select_in != `SU_MODE_OFF);
  wire mode_sync = (serial_mode_select_in == `SU_MODE_SYNC);
  wire mode_i2c  = (serial_mode_select_in == `SU_MODE_I2C);
  wire mode_sim  = (serial_mode_select_in == `SU_MODE_SIM);
  wire idle_lvl  = ~clock_polarity_sel_in;    // Clock rests high at polarity 0

  // Divider floor; values under three would let bits slip
  wire [7:0] i2c_div = (i2c_baud_divider_in < `SU_I2C_MIN_DIV) ?
                       `SU_I2C_MIN_DIV : i2c_baud_divider_in;
  wire [9:0] half    = {2'h0, i2c_div} + 10'h001;
  wire [9:0] dly     = {7'h00, sda_delay_in};

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers; only the second stage and its history are looked at
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      clk_s1 <= 1'b1;
      clk_s2 <= 1'b1;
      clk_s3 <= 1'b1;
      cts_s1 <= 1'b1;
      cts_s2 <= 1'b1;
      rxd_s1 <= 1'b1;
      rxd_s2 <= 1'b1;
    end else begin
      clk_s1 <= serial_clock_pin_in;
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
      cts_s1 <= cts_n_in;
      cts_s2 <= cts_s1;
      rxd_s1 <= receive_data_pin_in;
      rxd_s2 <= rxd_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge sources: the external pin or the internal divider
  wire ext_rise  = clk_s2 & ~clk_s3;
  wire ext_fall  = ~clk_s2 & clk_s3;
  wire div_tick  = internal_clk_sel_in & busy & (div_cnt == baud_div_in);
  // Leaving the rest level is the shift edge, returning is the sample edge
  wire int_shift = div_tick & (sclk_int == idle_lvl);
  wire int_samp  = div_tick & (sclk_int != idle_lvl);
  wire ext_shift = clock_polarity_sel_in ? ext_rise : ext_fall;
  wire ext_samp  = clock_polarity_sel_in ? ext_fall : ext_rise;
  wire shift_edge = busy & (internal_clk_sel_in ? int_shift :
                    (~internal_clk_sel_in & ext_shift));
  wire samp_edge  = busy & (internal_clk_sel_in ? int_samp :
                    (~internal_clk_sel_in & ext_samp));
  wire word_done  = samp_edge & (bitcnt == 3'h7);

  // Start needs enable and buffered data, CTS if used, and an external
  // clock resting at its idle level so the first edge is not half seen
  wire cts_ok     = ~cts_enable_in | ~cts_s2;
  wire lvl_ok     = internal_clk_sel_in | (clk_s2 == idle_lvl);
  wire start_go   = mode_sync & ~busy & tx_enable_bit_in & tx_full &
                    cts_ok & lvl_ok;

  // Drain the FIFO into tx_buffer whenever it is empty
  wire buf_load   = fifo_valid & ~tx_full;

  su_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH),
    .AW    ($clog2(FIFO_DEPTH))
  ) u_fifo (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .in_data_in    (tx_data_in),
    .in_valid_in   (tx_valid_in),
    .in_ready_out  (tx_ready_out),
    .out_data_out  (fifo_data),
    .out_valid_out (fifo_valid),
    .out_ready_in  (~tx_full)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Transmit buffer and shift engine
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      tx_buf   <= `SU_RST_WORD;
      tx_full  <= 1'b0;
      tx_sh    <= `SU_RST_WORD;
      rx_sh    <= `SU_RST_WORD;
      bitcnt   <= `SU_RST_BITCNT;
      busy     <= 1'b0;
      rx_on    <= 1'b0;
      sclk_int <= 1'b1;
      div_cnt  <= 8'h00;
      txd      <= 1'b1;
    end else begin
      if (buf_load) begin
        tx_buf  <= fifo_data;
        tx_full <= 1'b1;
      end else if (start_go) begin
        tx_full <= 1'b0;                      // Word moves to the shifter
      end
      if (!busy) begin
        sclk_int <= idle_lvl;
        div_cnt  <= 8'h00;
      end else if (div_tick) begin
        sclk_int <= ~sclk_int;                // Clock exists only while sending
        div_cnt  <= 8'h00;
      end else begin
        div_cnt  <= div_cnt + 8'h01;
      end
      if (start_go) begin
        tx_sh  <= tx_buf;                     // Buffered word; a start always needs tx_enable_bit_in and a full tx_buffer
        busy   <= 1'b1;
        rx_on  <= rx_enable_bit_in;
        bitcnt <= `SU_RST_BITCNT;
      end else begin
        if (shift_edge) begin
          txd <= tx_sh[0];
        end
        if (samp_edge) begin
          rx_sh  <= {rxd_s2, rx_sh[WORD_W-1:1]};
          tx_sh  <= {1'b1, tx_sh[WORD_W-1:1]};
          bitcnt <= bitcnt + 3'h1;
        end
        if (word_done || !mode_sync) begin
          busy <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive buffer, overrun and receive request; a new word beats a
  // same-cycle read, so the full flag never drops on fresh data
  wire rx_new = word_done & rx_on;
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      rx_buffer_out           <= `SU_RST_WORD;
      rx_buffer_full_flag_out <= 1'b0;
      overrun_flag_out        <= 1'b0;
      rx_irq_out              <= 1'b0;
    end else begin
      if (rx_new) begin
        rx_buffer_out           <= {rxd_s2, rx_sh[WORD_W-1:1]};
        rx_buffer_full_flag_out <= 1'b1;
      end else if (rx_read_in) begin
        rx_buffer_full_flag_out <= 1'b0;
      end
      if (rx_new && rx_buffer_full_flag_out) begin
        overrun_flag_out <= 1'b1;             // Buffer word now unreliable
      end else if (!mode_on) begin
        overrun_flag_out <= 1'b0;             // Cleared only by leaving serial mode
      end
      if (rx_new && !overrun_flag_out) begin
        rx_irq_out <= 1'b1;                   // Set wins over a clear
      end else if (irq_clear_in) begin
        rx_irq_out <= 1'b0;                   // Repeat overrun does not re-raise
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags and transmit request
  wire tx_cond = mode_on & (tx_irq_source_sel_in ? ~busy : ~tx_full) &
                 (~mode_sim | error_output_enable_in);
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      tx_shift_empty_out       <= 1'b1;
      tx_buffer_empty_flag_out <= 1'b1;
      tx_cond_prev             <= 1'b0;
      tx_irq_out               <= 1'b0;
    end else begin
      tx_shift_empty_out       <= ~busy;
      tx_buffer_empty_flag_out <= ~tx_full;
      tx_cond_prev             <= tx_cond;
      // Rising source sets; right after reset the completion source is
      // already true, so enabling it in SIM mode raises a request
      if (tx_cond && !tx_cond_prev) begin
        tx_irq_out <= 1'b1;
      end else if (irq_clear_in) begin
        tx_irq_out <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Condition requests: 0 to 1 edges are latched until generated or until I2C mode is left
  wire [2:0] req_now  = {stop_request_in, restart_request_in, start_request_in};
  wire [2:0] req_rise = req_now & ~req_prev;
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      req_prev <= 3'h0;
    end else begin
      req_prev <= req_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Condition generator: start holds SDA low half a period minus the SDA
  // delay before SCL falls; stop sets up half a period plus the delay
  wire g_run = mode_i2c & condition_output_select_in & (g_state == `SU_G_IDLE);
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      g_state       <= `SU_G_IDLE;
      g_cnt         <= `SU_RST_DIV;
      scl_gen       <= 1'b1;
      sda_gen       <= 1'b1;
      req_pend      <= 3'h0;
      cond_busy_out <= 1'b0;
    end else begin
      req_pend <= mode_i2c ? (req_pend | req_rise) : 3'h0;
      case (g_state)
        `SU_G_IDLE: begin
          g_cnt         <= `SU_RST_DIV;
          cond_busy_out <= 1'b0;
          if (g_run && req_pend[0]) begin
            g_state       <= `SU_G_START;
            req_pend[0]   <= 1'b0;
            cond_busy_out <= 1'b1;
          end else if (g_run && req_pend[1]) begin
            g_state       <= `SU_G_RESTART;
            req_pend[1]   <= 1'b0;
            cond_busy_out <= 1'b1;
          end else if (g_run && req_pend[2]) begin
            g_state       <= `SU_G_STOP;
            req_pend[2]   <= 1'b0;
            cond_busy_out <= 1'b1;
          end
        end
        `SU_G_START: begin
          g_cnt <= g_cnt + 10'h001;
          if (g_cnt == dly) begin
            sda_gen <= 1'b0;
          end
          if (g_cnt == half) begin
            scl_gen <= 1'b0;                  // Hold ends here
            g_state <= `SU_G_IDLE;
          end
        end
        `SU_G_RESTART: begin
          // Release SDA, then SCL, then run a normal start
          g_cnt <= g_cnt + 10'h001;
          if (g_cnt == dly) begin
            sda_gen <= 1'b1;
          end
          if (g_cnt == half) begin
            scl_gen <= 1'b1;
            g_cnt   <= `SU_RST_DIV;
            g_state <= `SU_G_START;
          end
        end
        `SU_G_STOP: begin
          g_cnt <= g_cnt + 10'h001;
          if (g_cnt == dly) begin
            sda_gen <= 1'b0;
          end
          if (g_cnt == half) begin
            scl_gen <= 1'b1;
          end
          if (g_cnt == half + half + dly) begin
            sda_gen <= 1'b1;                  // Setup is half plus delay
            g_state <= `SU_G_IDLE;
          end
        end
        default: begin
          g_state <= `SU_G_IDLE;
        end
      endcase
      if (!mode_i2c) begin
        g_state <= `SU_G_IDLE;                // Leaving I2C aborts a condition
        scl_gen <= 1'b1;
        sda_gen <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers, all registered; open drain only ever drives low, and the
  // pin is a plain port whenever the mode is off
  wire clk_lvl  = mode_i2c ? scl_gen : sclk_int;
  wire clk_drv  = mode_i2c | (mode_on & internal_clk_sel_in);
  wire data_lvl = mode_i2c ? sda_gen : txd;
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      serial_clock_pin_out       <= 1'b1;
      serial_clock_pin_oe_n_out  <= 1'b1;
      transmit_data_pin_out      <= 1'b1;
      transmit_data_pin_oe_n_out <= 1'b1;
      rts_n_out                  <= 1'b1;
    end else begin
      serial_clock_pin_out       <= clk_lvl;
      serial_clock_pin_oe_n_out  <= ~clk_drv |
                                    ((clk_open_drain_sel_in | mode_i2c) & clk_lvl);
      transmit_data_pin_out      <= data_lvl;
      transmit_data_pin_oe_n_out <= ~mode_on | (mode_i2c & data_lvl);
      // Ready to receive while idle on the external clock; forced off
      // with the internal clock since the far side cannot pace us then
      rts_n_out <= ~(mode_sync & rts_enable_in & ~internal_clk_sel_in &
                     rx_enable_bit_in & ~busy);
    end
  end
endmodule // su_serial_unit
`default_nettype wire

// file: testbench/su_serial_unit_assertions.sv
// Port-level checks for the serial unit
`timescale 1ns/1ps
`default_nettype none
`include "su_defines.vh"
module su_serial_unit_assertions (
  input wire logic       clk_in,                   // Clock
  input wire logic       rst_n_in,                 // Reset, low
  input wire logic [2:0] serial_mode_select_in,    // Mode
  input wire logic       internal_clk_sel_in,      // Own clock
  input wire logic       tx_enable_bit_in,         // Tx enable
  input wire logic       rx_enable_bit_in,         // Rx enable
  input wire logic       rx_read_in,               // Buffer read
  input wire logic       rx_buffer_full_flag_out,  // Full
  input wire logic       overrun_flag_out,         // Overrun
  input wire logic       rx_irq_out,               // Rx request
  input wire logic       tx_irq_out,               // Tx request
  input wire logic       tx_shift_empty_out,       // Shift empty
  input wire logic       tx_buffer_empty_flag_out, // Buffer empty
  input wire logic       rts_n_out                 // RTS
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Outputs are registered, so each cause is looked up one cycle back
  a_rts_int_off: assert property (internal_clk_sel_in [*2] |-> rts_n_out)
    else $error("rts active with internal clock");
  a_rts_busy: assert property (!tx_shift_empty_out [*2] |-> rts_n_out)
    else $error("rts active during a frame");
  a_ovr_cause: assert property ($rose(overrun_flag_out) |-> $past(rx_buffer_full_flag_out))
    else $error("overrun without full buffer");
  a_irq_keep: assert property ($past(overrun_flag_out) |-> !$rose(rx_irq_out))
    else $error("rx request set again on overrun");
  a_start_needs: assert property ($fell(tx_shift_empty_out) |->
    !$past(tx_buffer_empty_flag_out) && $past(tx_enable_bit_in))
    else $error("shift started without word or enable");
  a_rx_enabled: assert property ($rose(rx_buffer_full_flag_out) |-> $past(rx_enable_bit_in))
    else $error("word received while disabled");
  a_full_clear: assert property ($fell(rx_buffer_full_flag_out) |-> $past(rx_read_in))
    else $error("full flag dropped without read");
  a_txirq_mode: assert property ($rose(tx_irq_out) |->
    $past(serial_mode_select_in) != `SU_MODE_OFF)
    else $error("tx request while unit off");
  c_overrun: cover property ($rose(overrun_flag_out));
  c_frame: cover property ($fell(tx_shift_empty_out));
  c_txirq: cover property ($rose(tx_irq_out));
endmodule // su_serial_unit_assertions
bind su_serial_unit su_serial_unit_assertions u_chk (.*);
`default_nettype wire

// file: testbench/su_partner.sv
// Far-side serial device: makes the shift clock and data of one frame
`timescale 1ns/1ps
`default_nettype none
module su_partner (
  input  wire logic       go_in,    // Rising edge starts a frame
  input  wire logic [7:0] data_in,  // Word to send
  input  wire logic       txd_in,   // Unit's transmit pin
  output var  logic       sclk_out, // Shift clock
  output var  logic       rxd_out,  // Data to the unit
  output var  logic [7:0] got_out,  // Word captured
  output var  logic       done_out  // Frame over
);
  // Clock rests high between frames, so each start meets the idle level
  initial {sclk_out, rxd_out, got_out, done_out} = 11'h400;
  // 48 ns clock only inside the frame: shift on fall, sample on rise
  always @(posedge go_in) begin
    done_out = 0;
    for (int i = 0; i < 8; i++) begin
      sclk_out = 0;
      rxd_out = data_in[i];
      #24 sclk_out = 1;
      got_out[i] = txd_in;
      #24;
    end
    rxd_out = ~rxd_out; // Released line shows no stale bit
    done_out = 1;
  end
endmodule // su_partner
`default_nettype wire

// file: testbench/tb_su_serial_unit.sv
// Self-checking bench for the serial unit
`timescale 1ns/1ps
`default_nettype none
`include "su_defines.vh"
module tb_su_serial_unit;
  logic clk_in, rst_n_in, clk_open_drain_sel_in, internal_clk_sel_in, clock_polarity_sel_in;
  logic tx_enable_bit_in, rx_enable_bit_in, rts_enable_in, cts_enable_in, cts_n_in, irq_clear_in;
  logic condition_output_select_in, start_request_in, restart_request_in, stop_request_in;
  logic tx_irq_source_sel_in, error_output_enable_in, tx_valid_in, tx_ready_out, rx_read_in;
  logic rx_buffer_full_flag_out, overrun_flag_out, rx_irq_out, tx_irq_out, tx_shift_empty_out;
  logic tx_buffer_empty_flag_out, cond_busy_out, serial_clock_pin_in, serial_clock_pin_out;
  logic serial_clock_pin_oe_n_out, receive_data_pin_in, transmit_data_pin_out, rts_n_out;
  logic transmit_data_pin_oe_n_out, ext, p_go, p_sclk, p_rxd, p_done, auto_rd;
  logic [2:0] serial_mode_select_in, sda_delay_in;
  logic [7:0] baud_div_in, i2c_baud_divider_in, tx_data_in, rx_buffer_out, p_got, b;
  logic [7:0] exp_q[$];
  int bad_count, n_tests, k;
  su_serial_unit u_dut (.*);
  su_partner u_far (.go_in(p_go), .data_in(b), .txd_in(transmit_data_pin_out),
    .sclk_out(p_sclk), .rxd_out(p_rxd), .got_out(p_got), .done_out(p_done));
  // Released pins read the pull-up level; loopback unless the partner runs
  assign serial_clock_pin_in = ext ? p_sclk : serial_clock_pin_oe_n_out | serial_clock_pin_out;
  assign receive_data_pin_in = ext ? p_rxd : transmit_data_pin_oe_n_out | transmit_data_pin_out;
  initial begin
    clk_in = 0;
    forever #2.5 clk_in = ~clk_in;
  end
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    if (bad_count == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // A used-up wait counts as a failure and ends the run
  task automatic tmo(input int lim);
    if (k >= lim) begin
      bad_count++;
      finish_test();
    end
  endtask
  // Each received word is compared with the oldest note, then read out
  always @(negedge clk_in) begin
    rx_read_in <= auto_rd && rx_buffer_full_flag_out && !rx_read_in;
    if (auto_rd && rx_buffer_full_flag_out && !rx_read_in)
      chk("rx_buffer", rx_buffer_out, exp_q.pop_front());
  end
  initial begin
    {rst_n_in, clk_open_drain_sel_in, clock_polarity_sel_in, tx_enable_bit_in, rx_enable_bit_in,
     cts_enable_in, cts_n_in, tx_valid_in, condition_output_select_in, start_request_in,
     restart_request_in, stop_request_in, irq_clear_in, ext, p_go, auto_rd} = '0;
    {serial_mode_select_in, sda_delay_in, baud_div_in, i2c_baud_divider_in, tx_data_in, b} = '0;
    {internal_clk_sel_in, rts_enable_in, tx_irq_source_sel_in, error_output_enable_in} = '1;
    k = $urandom(4070);
    repeat (12) @(negedge clk_in);
    rst_n_in = 1;
    chk("shift_empty", tx_shift_empty_out, 8'h01);
    serial_mode_select_in = `SU_MODE_SIM;
    for (k = 0; k < 20 && !tx_irq_out; k++) @(negedge clk_in);
    chk("tx_irq", tx_irq_out, 8'h01);
    irq_clear_in = 1;
    @(negedge clk_in);
    irq_clear_in = 0;
    chk("tx_irq", tx_irq_out, 8'h00);
    // Fill the FIFO with transmission held off, then drain it by loopback
    serial_mode_select_in = `SU_MODE_SYNC;
    clk_open_drain_sel_in = 1;
    baud_div_in = 8'h05;
    rx_enable_bit_in = 1;
    tx_valid_in = 1;
    for (k = 0; k < 40 && tx_ready_out; k++) begin
      tx_data_in = 8'($urandom);
      exp_q.push_back(tx_data_in);
      @(negedge clk_in);
    end
    tx_valid_in = 0;
    chk("fifo_room", 8'(k >= 32), 8'h01);
    chk("buf_empty", tx_buffer_empty_flag_out, 8'h00);
    chk("shift_empty", tx_shift_empty_out, 8'h01);
    tx_enable_bit_in = 1;
    auto_rd = 1;
    for (k = 0; k < 9000 && exp_q.size() > 0; k++) @(negedge clk_in);
    tmo(9000);
    chk("clk_oe_n", serial_clock_pin_oe_n_out, 8'h01);
    // External clock frame from the partner, both directions at once
    internal_clk_sel_in = 0;
    clk_open_drain_sel_in = 0;
    ext = 1;
    repeat (4) @(negedge clk_in);
    chk("rts_n", rts_n_out, 8'h00);
    tx_data_in = 8'($urandom);
    b = 8'($urandom);
    exp_q.push_back(b);
    tx_valid_in = 1;
    @(negedge clk_in);
    tx_valid_in = 0;
    repeat (8) @(negedge clk_in);
    p_go = 1;
    for (k = 0; k < 200 && !(p_done && exp_q.size() == 0); k++) @(negedge clk_in);
    tmo(200);
    chk("far_rx", p_got, tx_data_in);
    // Start condition: SDA falls H-D cycles before SCL; no restart used
    ext = 0;
    serial_mode_select_in = `SU_MODE_OFF;
    @(negedge clk_in);
    serial_mode_select_in = `SU_MODE_I2C;
    i2c_baud_divider_in = 8'h03;
    sda_delay_in = 3'h1;
    repeat (10) @(negedge clk_in);
    start_request_in = 1;
    @(negedge clk_in);
    condition_output_select_in = 1;
    for (k = 0; k < 50 && transmit_data_pin_oe_n_out; k++) @(negedge clk_in);
    tmo(50);
    chk("cond_busy", cond_busy_out, 8'h01);
    for (k = 0; k < 50 && serial_clock_pin_oe_n_out; k++) @(negedge clk_in);
    chk("start_hold", 8'(k), 8'h03);
    // Three words unread: overrun, then a second one leaves the request alone
    {condition_output_select_in, start_request_in, auto_rd} = '0;
    serial_mode_select_in = `SU_MODE_SYNC;
    internal_clk_sel_in = 1;
    tx_valid_in = 1;
    repeat (3) @(negedge clk_in);
    tx_valid_in = 0;
    for (k = 0; k < 2000 && !overrun_flag_out; k++) @(negedge clk_in);
    chk("overrun", overrun_flag_out, 8'h01);
    irq_clear_in = 1;
    @(negedge clk_in);
    irq_clear_in = 0;
    for (k = 0; k < 2000 && !(tx_shift_empty_out && tx_buffer_empty_flag_out); k++)
      @(negedge clk_in);
    tmo(2000);
    repeat (3) @(negedge clk_in);
    chk("rx_irq", rx_irq_out, 8'h00);
    finish_test();
  end
endmodule // tb_su_serial_unit
`default_nettype wire
